// file: hdl/sdf_defs.svh
`ifndef SDF_DEFS_SVH
`define SDF_DEFS_SVH

// Register byte offsets
`define SDF_OFS_MODE    4'h0
`define SDF_OFS_CFG     4'h4
`define SDF_OFS_STAT    4'h8
`define SDF_OFS_DATA    4'hC

// Mode register fields
`define SDF_FW_MSB      9
`define SDF_DUAL_BIT    10
`define SDF_ZL_BIT      11
`define SDF_THIRD_BIT   15
`define SDF_MODE_RST    32'h0000_0060
`define SDF_MODE_MASK   32'h0000_8FFF

// Configuration register fields
`define SDF_SEQ_BIT     0
`define SDF_CHOP_BIT    1
`define SDF_AVG_BIT     2
`define SDF_CFG_RST     32'h0000_0000
`define SDF_CFG_MASK    32'h0000_0007

// Status register fields
`define SDF_ST_RDY_BIT  0
`define SDF_ST_SET_BIT  1
`define SDF_ST_IDLE_BIT 2
`define SDF_ST_ZL_BIT   3

// Timing
`define SDF_CLK_HZ      250000000
`define SDF_MCLK_HZ     4920000
`define SDF_MOD_DIV     16
`define SDF_PERIOD_MCLK 1024

// Filter
`define SDF_ORD4        3'h4
`define SDF_ORD3        3'h3
`define SDF_MIDCODE     24'h80_0000
`define SDF_POS_MAX     24'h7F_FFFF
`define SDF_ACC_W       66

`endif

// file: hdl/sdf_pkg.sv
`include "sdf_defs.svh"

package sdf_pkg;

    typedef enum logic [1:0] {
        SDF_ST_IDLE,
        SDF_ST_SETTLE,
        SDF_ST_RUN
    } sdf_state_e;

    typedef logic [`SDF_ACC_W-1:0] sdf_acc_t;

endpackage : sdf_pkg

// file: hdl/sdf_cic_if.sv
`timescale 1ns/1ns

interface sdf_cic_if;
    logic             tick;
    logic             sbit;
    logic             clear;
    sdf_pkg::sdf_acc_t i3;
    sdf_pkg::sdf_acc_t i4;

    modport gen  (output tick, output sbit);
    modport core (input tick, input sbit, input clear,
                  output i3, output i4);
    modport ctrl (input tick, input i3, input i4, output clear);
endinterface : sdf_cic_if

// file: hdl/sdf_mclk_gen.sv
`timescale 1ns/1ns
`include "sdf_defs.svh"

module sdf_mclk_gen
    import sdf_pkg::*;
#(
    parameter int unsigned CLK_HZ  = `SDF_CLK_HZ,
    parameter int unsigned MCLK_HZ = `SDF_MCLK_HZ,
    parameter int unsigned MOD_DIV = `SDF_MOD_DIV
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic mod_bit_i,
    sdf_cic_if.gen    cif
);
    localparam int DW = $clog2(MOD_DIV);
    localparam logic [31:0] STEP = 32'(MCLK_HZ);
    localparam logic [31:0] WRAP = 32'(CLK_HZ);

    logic [31:0]   phase_q;
    logic [31:0]   phase_sum;
    logic          mclk_stb;
    logic [DW-1:0] div_q;
    logic          bit_s1_q;
    logic          bit_s2_q;
    logic          tick_q;
    logic          sbit_q;

    // Fractional divider: mean strobe rate is exactly the master clock; tick is one in 16 strobes
    assign phase_sum = phase_q + STEP;
    assign mclk_stb  = phase_sum >= WRAP;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_q <= '0;
            div_q   <= '0;
        end else begin
            phase_q <= mclk_stb ? phase_sum - WRAP : phase_sum;
            if (mclk_stb) begin
                div_q <= (div_q == DW'(MOD_DIV - 1)) ? '0 : div_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_s1_q <= 1'b0;
            bit_s2_q <= 1'b0;
            tick_q   <= 1'b0;
            sbit_q   <= 1'b0;
        end else begin
            bit_s1_q <= mod_bit_i;
            bit_s2_q <= bit_s1_q;
            tick_q   <= mclk_stb && (div_q == DW'(MOD_DIV - 1));
            if (mclk_stb && (div_q == DW'(MOD_DIV - 1))) begin
                sbit_q <= bit_s2_q;
            end
        end
    end

    assign cif.tick = tick_q;
    assign cif.sbit = sbit_q;
endmodule : sdf_mclk_gen

// file: hdl/sdf_cic.sv
`timescale 1ns/1ns
`include "sdf_defs.svh"

module sdf_cic
    import sdf_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    sdf_cic_if.core   cif
);
    sdf_acc_t acc_q [4];
    sdf_acc_t sample;

    // Bitstream maps to +1 or -1
    assign sample = {{(`SDF_ACC_W-1){~cif.sbit}}, 1'b1};

    // Wraparound arithmetic is intended; the combs undo it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int k = 0; k < 4; k++) acc_q[k] <= '0;
        end else if (cif.clear) begin
            for (int k = 0; k < 4; k++) acc_q[k] <= '0;
        end else if (cif.tick) begin
            acc_q[0] <= acc_q[0] + sample;
            for (int k = 1; k < 4; k++) acc_q[k] <= acc_q[k] + acc_q[k-1];
        end
    end

    assign cif.i3 = acc_q[2];
    assign cif.i4 = acc_q[3];
endmodule : sdf_cic

// file: hdl/sdf_top.sv
// Notes on behaviour
// - Reset selects fourth order, chop off
// - Normal mode: one word per 1024*word clocks
// - Filter word is ten bits, 1 to 1023
// - All timing derived from 4.92 MHz clock
// - Fourth order settles in four word periods
// - Channel change resets, settles, then streams
// - Input step keeps rate; settles after four
// - Fourth order corner at 0.23 word rate
// - Mode bit 11 enables zero latency
// - Zero latency settles every conversion fully
// - Sequencer on forces zero latency
// - Zero latency period is one word period per order: four, or three in third order
// - Zero latency: async step, one unsettled
// - Word 96 gives 50 or 12.5 Hz
// - Word 80 gives 60 or 15 Hz
// - Word 480 notches both, 10/2.5 Hz
// - Dual notch at 96 keeps 50/12.5 Hz
// - Order, chop, latency, averaging are selectable; the chop and averaging bits are only stored and have no effect
// - Third order when select bit set
// - Resync pin or mode/cfg write restarts
`timescale 1ns/1ns
`include "sdf_defs.svh"

module sdf_top
    import sdf_pkg::*;
#(
    parameter int unsigned CLK_HZ  = `SDF_CLK_HZ,
    parameter int unsigned MCLK_HZ = `SDF_MCLK_HZ
) (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        mod_bit_i,
    input  wire logic        filter_resync_b_i,
    input  wire logic        channel_change_i,
    output logic             mod_reset_o,
    output logic             data_ready_b_o,
    output logic      [23:0] data_word_o
);
    localparam int DEC_LOG2 = $clog2(`SDF_PERIOD_MCLK / `SDF_MOD_DIV);

    function automatic int sdf_clog2(input logic [9:0] v);
        int r;
        r = 0;
        for (int i = 0; i < 10; i++) begin
            if (32'(v) > (32'h1 << i)) r = i + 1;
        end
        return r;
    endfunction : sdf_clog2

    function automatic logic [31:0] sdf_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[8*b +: 8] = wd[8*b +: 8];
        end
        return r;
    endfunction : sdf_merge

    // Shift by the full comb gain so a full-scale input lands at 24 bits
    function automatic logic [23:0] sdf_scale(input sdf_acc_t   y,
                                              input logic [2:0] ord,
                                              input logic [9:0] fw);
        int       sh;
        sdf_acc_t t;
        sh = int'(ord) * (DEC_LOG2 + sdf_clog2(fw)) - 23;
        if (sh >= 0) t = sdf_acc_t'($signed(y) >>> sh);
        else t = sdf_acc_t'(y << (-sh));
        if (!t[`SDF_ACC_W-1] && (t[`SDF_ACC_W-2:23] != '0)) begin
            return `SDF_POS_MAX;
        end
        return t[23:0];
    endfunction : sdf_scale

    // Dual notch comb reaches back five sixths of a word period
    function automatic logic [15:0] sdf_notch_pt(input logic [9:0] fw);
        logic [15:0] r;
        r = {1'b0, fw, 5'h0_0} / 16'h0003;
        return r;
    endfunction : sdf_notch_pt

    sdf_cic_if cif ();

    sdf_mclk_gen #(
        .CLK_HZ  (CLK_HZ),
        .MCLK_HZ (MCLK_HZ),
        .MOD_DIV (`SDF_MOD_DIV)
    ) u_mclk (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .mod_bit_i (mod_bit_i),
        .cif       (cif.gen)
    );

    sdf_cic u_cic (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .cif     (cif.core)
    );

    logic [31:0] mode_q;
    logic [31:0] cfg_q;
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;
    logic        acc_ok;
    logic        wr_mode;
    logic        wr_cfg;
    logic        rd_data;
    logic        rsy_s1_q;
    logic        rsy_s2_q;
    logic        resync;
    logic        clear_q;
    logic        mreset_q;
    logic [9:0]  fw;
    logic        third;
    logic        dual;
    logic        zl_eff;
    logic [2:0]  ord;
    logic [15:0] dec_len;
    logic [15:0] samp_cnt_q;
    logic        dec_stb_q;
    logic        snap_stb_q;
    sdf_acc_t    snap_q;
    sdf_acc_t    d_q [4];
    sdf_acc_t    x;
    sdf_acc_t    c [4];
    sdf_acc_t    y;
    logic [2:0]  words_q;
    logic [2:0]  zl_ph_q;
    logic        out_stb;
    logic [23:0] data_q;
    logic        rdy_q;
    logic        rdy_d;
    logic        rdy_b_q;
    logic        settled_q;
    sdf_state_e  state_q;

    // Bus slave: waitrequest drops for one cycle per request
    assign acc_ok  = (avs_read_i || avs_write_i) && !wait_q;
    assign wr_mode = acc_ok && avs_write_i
                     && (avs_address_i == `SDF_OFS_MODE);
    assign wr_cfg  = acc_ok && avs_write_i
                     && (avs_address_i == `SDF_OFS_CFG);
    assign rd_data = acc_ok && avs_read_i
                     && (avs_address_i == `SDF_OFS_DATA);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((avs_read_i || avs_write_i) && wait_q);
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address_i)
            `SDF_OFS_MODE: rd_mux = mode_q;
            `SDF_OFS_CFG:  rd_mux = cfg_q;
            `SDF_OFS_STAT: begin
                rd_mux[`SDF_ST_RDY_BIT]  = rdy_q;
                rd_mux[`SDF_ST_SET_BIT]  = settled_q;
                rd_mux[`SDF_ST_IDLE_BIT] = (state_q == SDF_ST_IDLE);
                rd_mux[`SDF_ST_ZL_BIT]   = zl_eff;
            end
            `SDF_OFS_DATA: rd_mux = {8'h00, data_q};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && wait_q) begin
            rdata_q <= rd_mux;
        end
    end

    // Unused bits are masked so they read back as zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_q <= `SDF_MODE_RST;
            cfg_q  <= `SDF_CFG_RST;
        end else begin
            if (wr_mode) begin
                mode_q <= sdf_merge(mode_q, avs_writedata_i,
                                    avs_byteenable_i) & `SDF_MODE_MASK;
            end
            if (wr_cfg) begin
                cfg_q <= sdf_merge(cfg_q, avs_writedata_i,
                                   avs_byteenable_i) & `SDF_CFG_MASK;
            end
        end
    end

    assign fw     = mode_q[`SDF_FW_MSB:0];
    assign third  = mode_q[`SDF_THIRD_BIT];
    assign dual   = mode_q[`SDF_DUAL_BIT];
    assign zl_eff = mode_q[`SDF_ZL_BIT]
                    || cfg_q[`SDF_SEQ_BIT];
    assign ord    = third ? `SDF_ORD3 : `SDF_ORD4;
    assign dec_len = {fw, 6'h00};

    // Resync pin is asynchronous to this clock
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsy_s1_q <= 1'b1;
            rsy_s2_q <= 1'b1;
        end else begin
            rsy_s1_q <= filter_resync_b_i;
            rsy_s2_q <= rsy_s1_q;
        end
    end

    assign resync = !rsy_s2_q || wr_mode || wr_cfg
                    || channel_change_i
                    || (fw == '0);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clear_q  <= 1'b1;
            mreset_q <= 1'b1;
        end else begin
            clear_q  <= resync;
            mreset_q <= resync;
        end
    end

    assign cif.clear = clear_q;

    // Decimation: word period is 64*fw modulator samples
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            samp_cnt_q <= '0;
            dec_stb_q  <= 1'b0;
            snap_stb_q <= 1'b0;
        end else if (clear_q) begin
            samp_cnt_q <= '0;
            dec_stb_q  <= 1'b0;
            snap_stb_q <= 1'b0;
        end else begin
            dec_stb_q  <= cif.tick && (samp_cnt_q == dec_len - 16'h0001);
            snap_stb_q <= cif.tick
                          && (samp_cnt_q == sdf_notch_pt(fw) - 16'h0001);
            if (cif.tick) begin
                if (samp_cnt_q == dec_len - 16'h0001) begin
                    samp_cnt_q <= '0;
                end else begin
                    samp_cnt_q <= samp_cnt_q + 16'h0001;
                end
            end
        end
    end

    // Combs run once per word at the decimated rate
    always_comb begin
        x    = third ? cif.i3 : cif.i4;
        c[0] = x - (dual ? snap_q : d_q[0]);
        c[1] = c[0] - d_q[1];
        c[2] = c[1] - d_q[2];
        c[3] = c[2] - d_q[3];
        y    = third ? c[2] : c[3];
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            snap_q <= '0;
            for (int k = 0; k < 4; k++) d_q[k] <= '0;
        end else if (clear_q) begin
            snap_q <= '0;
            for (int k = 0; k < 4; k++) d_q[k] <= '0;
        end else begin
            if (snap_stb_q) begin
                snap_q <= third ? cif.i3 : cif.i4;
            end
            if (dec_stb_q) begin
                d_q[0] <= x;
                for (int k = 1; k < 4; k++) d_q[k] <= c[k-1];
            end
        end
    end

    // Settling: stages are empty after a restart, so the first
    // order-th word is the earliest that carries no stale history
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            words_q <= '0;
            zl_ph_q <= '0;
        end else if (clear_q) begin
            words_q <= '0;
            zl_ph_q <= '0;
        end else if (dec_stb_q) begin
            if (words_q != ord) words_q <= words_q + 3'h1;
            if (zl_ph_q == ord - 3'h1) zl_ph_q <= '0;
            else zl_ph_q <= zl_ph_q + 3'h1;
        end
    end

    // Normal mode streams every word once settled; zero latency
    // only emits words whose whole window is fresh
    assign out_stb = dec_stb_q && !clear_q
                     && (zl_eff ? (zl_ph_q == ord - 3'h1)
                                : (words_q >= ord - 3'h1));

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_q <= `SDF_MIDCODE;
        end else if (out_stb) begin
            data_q <= sdf_scale(y, ord, fw) ^ `SDF_MIDCODE;
        end
    end

    // New word sets ready even in the cycle it is read
    assign rdy_d = out_stb || (rdy_q && !rd_data);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdy_q   <= 1'b0;
            rdy_b_q <= 1'b1;
        end else begin
            rdy_q   <= rdy_d;
            rdy_b_q <= !rdy_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q   <= SDF_ST_IDLE;
            settled_q <= 1'b0;
        end else begin
            unique case (state_q)
                SDF_ST_IDLE: begin
                    settled_q <= 1'b0;
                    if (fw != '0) state_q <= SDF_ST_SETTLE;
                end
                SDF_ST_SETTLE: begin
                    if (fw == '0) state_q <= SDF_ST_IDLE;
                    else if (out_stb) begin
                        state_q   <= SDF_ST_RUN;
                        settled_q <= 1'b1;
                    end
                end
                SDF_ST_RUN: begin
                    if (fw == '0) state_q <= SDF_ST_IDLE;
                    else if (resync) begin
                        state_q   <= SDF_ST_SETTLE;
                        settled_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Rates follow from fw and order: 96, 80, 480 give 50, 60, 10 Hz
    // normal, and a quarter of that (a third in third order) with zero latency
    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign mod_reset_o       = mreset_q;
    assign data_ready_b_o    = rdy_b_q;
    assign data_word_o       = data_q;
endmodule : sdf_top

// file: tb/sdf_top_assertions.sv
`timescale 1ns/1ns

module sdf_top_assertions #(
    parameter int unsigned CLK_HZ  = 250000000,
    parameter int unsigned MCLK_HZ = 4920000
) (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        mod_bit_i,
    input wire logic        filter_resync_b_i,
    input wire logic        channel_change_i,
    input wire logic        mod_reset_o,
    input wire logic        data_ready_b_o,
    input wire logic [23:0] data_word_o
);
    // Third order is the shortest settling; integer ratio errs on the safe side
    localparam int MIN_GAP = 3 * 1024 * (CLK_HZ / MCLK_HZ) - 64;
    int unsigned gap_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gap_q <= 0;
        end else if (mod_reset_o) begin
            gap_q <= 0;
        end else begin
            gap_q <= gap_q + 1;
        end
    end

    sequence take_s;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence cfg_wr_s;
        avs_write_i && avs_waitrequest_o && avs_address_i inside {4'h0, 4'h4}
        ##1 !avs_waitrequest_o;
    endsequence
    sequence data_rd_s;
        avs_read_i && avs_waitrequest_o && avs_address_i == 4'hC
        ##1 !avs_waitrequest_o;
    endsequence

    wait_one_a: assert property (take_s |=> !avs_waitrequest_o)
        else $error("request not answered after one wait cycle");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o &&
        avs_address_i[1:0] != 2'b00 |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");
    write_restart_a: assert property (cfg_wr_s |=> mod_reset_o)
        else $error("mode or cfg write did not reset the filter");
    resync_hold_a: assert property (!filter_resync_b_i [*4] |-> mod_reset_o)
        else $error("held resync did not hold the filter in reset");
    chan_restart_a: assert property (channel_change_i |-> ##[1:3] mod_reset_o)
        else $error("channel change did not reset the filter");
    settle_gap_a: assert property ($fell(data_ready_b_o) |-> gap_q >= MIN_GAP)
        else $error("result before the settling interval ran out");
    read_clear_a: assert property (data_rd_s |=>
        data_ready_b_o || !$stable(data_word_o))
        else $error("data read did not clear ready");
endmodule : sdf_top_assertions

bind sdf_top sdf_top_assertions #(
    .CLK_HZ  (CLK_HZ),
    .MCLK_HZ (MCLK_HZ)
) sdf_top_assertions_i (
    .clk_i             (clk_i),
    .rst_b_i           (rst_b_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .mod_bit_i         (mod_bit_i),
    .filter_resync_b_i (filter_resync_b_i),
    .channel_change_i  (channel_change_i),
    .mod_reset_o       (mod_reset_o),
    .data_ready_b_o    (data_ready_b_o),
    .data_word_o       (data_word_o)
);

// file: tb/sdf_mod_model.sv
`timescale 1ns/1ns

module sdf_mod_model (
    input  wire logic       clk_i,
    input  wire logic [1:0] dens_i,
    output logic            mod_bit_o
);
    logic tgl_q = 1'b0;

    always_ff @(posedge clk_i) begin
        tgl_q <= ~tgl_q;
    end

    // Fixed levels give full-scale codes; the toggle is a mid-density stream
    always_comb begin
        case (dens_i)
            2'd0:    mod_bit_o = 1'b0;
            2'd1:    mod_bit_o = tgl_q;
            default: mod_bit_o = 1'b1;
        endcase
    end
endmodule : sdf_mod_model

// file: tb/sdf_top_tb_top.sv
`timescale 1ns/1ns

module sdf_top_tb_top;
    // One word period at fw=1: 1024 master clocks of two clocks each
    localparam int P = 2048;
    logic        clk_i             = 1'b0;
    logic        rst_b_i           = 1'b0;
    logic [3:0]  avs_address_i     = 4'h0;
    logic        avs_read_i        = 1'b0;
    logic        avs_write_i       = 1'b0;
    logic [31:0] avs_writedata_i   = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i  = 4'hF;
    logic        filter_resync_b_i = 1'b1;
    logic        channel_change_i  = 1'b0;
    logic [1:0]  dens              = 2'd2;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        mod_bit_i;
    logic        mod_reset_o;
    logic        data_ready_b_o;
    logic [23:0] data_word_o;
    logic [31:0] q;
    int          t;
    int          t0;
    int          cyc          = 0;
    int          miscompares  = 0;
    int          total_checks = 0;

    // Raised master clock rate keeps each word period short
    sdf_top #(.CLK_HZ(250000000), .MCLK_HZ(125000000)) sdf_top_i (
        .clk_i             (clk_i),
        .rst_b_i           (rst_b_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .mod_bit_i         (mod_bit_i),
        .filter_resync_b_i (filter_resync_b_i),
        .channel_change_i  (channel_change_i),
        .mod_reset_o       (mod_reset_o),
        .data_ready_b_o    (data_ready_b_o),
        .data_word_o       (data_word_o)
    );

    sdf_mod_model sdf_mod_model_i (
        .clk_i     (clk_i),
        .dens_i    (dens),
        .mod_bit_o (mod_bit_i)
    );

    always #2 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
    end

    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task chkr(input int got, input int lo, input int hi, input string m);
        total_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("wrong value at %0t: %s took %0d", $time, m, got);
        end
    endtask : chkr

    // Holds the request until waitrequest is sampled low, then one idle cycle
    task bus(input bit wr, input logic [3:0] a, input logic [31:0] d,
             output logic [31:0] r);
        int n;
        n = 0;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        chkr(n, 1, 49, "bus answer");
        r = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    // Waits for a result, stamps it (-1 on timeout) and reads it out
    task res(input int lim, output int ts, output logic [31:0] w);
        int n;
        n = 0;
        while (data_ready_b_o !== 1'b0 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        ts = (n < lim) ? cyc : -1;
        bus(0, 4'hC, 32'h0000_0000, w);
    endtask : res

    task run(input logic [31:0] md, input logic [31:0] cf, input int first,
             input int nxt, input int n, output logic [31:0] w);
        int t1;
        int t2;
        bus(1, 4'h4, cf, w);
        bus(1, 4'h0, md, w);
        t1 = cyc;
        res(first + 600, t2, w);
        chkr(t2 - t1, first - P / 4, first + P / 4, "first result");
        for (int k = 1; k < n; k++) begin
            t1 = t2;
            res(nxt + 600, t2, w);
            chkr(t2 - t1, nxt - 8, nxt + 8, "result spacing");
        end
        $display("test mode %h cfg %h done", md, cf);
    endtask : run

    initial begin
        repeat (99000) @(posedge clk_i);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        chk(32'(mod_reset_o), 32'h0000_0001, "reset state");
        chk({7'h00, data_ready_b_o, data_word_o}, 32'h0180_0000, "reset out");
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        bus(0, 4'h0, 32'h0000_0000, q);
        chk(q, 32'h0000_0060, "mode reset");
        bus(0, 4'h4, 32'h0000_0000, q);
        chk(q, 32'h0000_0000, "cfg reset");
        bus(0, 4'h2, 32'h0000_0000, q);
        chk(q, 32'h0000_0000, "unmapped read");
        bus(1, 4'h0, 32'hFFFF_FFFF, q);
        bus(0, 4'h0, 32'h0000_0000, q);
        chk(q, 32'h0000_8FFF, "mode fields");
        avs_byteenable_i <= 4'h1;
        bus(1, 4'h0, 32'h0000_0000, q);
        avs_byteenable_i <= 4'hF;
        bus(0, 4'h0, 32'h0000_0000, q);
        chk(q, 32'h0000_8F00, "byte lane write");
        $display("test registers done");
        filter_resync_b_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(32'(mod_reset_o), 32'h0000_0001, "resync hold");
        filter_resync_b_i <= 1'b1;
        @(posedge clk_i);
        bus(1, 4'h0, 32'h0000_0000, q);
        bus(0, 4'h8, 32'h0000_0000, q);
        chk(q & 32'h0000_0004, 32'h0000_0004, "idle flag");
        res(5 * P, t, q);
        chk(32'(t), 32'hFFFF_FFFF, "no result at zero word");
        $display("test resync and idle done");
        run(32'h0000_0001, 32'h0000_0000, 4 * P, P, 3, q);
        chk(q, 32'h00FF_FFFF, "settled full scale");
        channel_change_i <= 1'b1;
        @(posedge clk_i);
        channel_change_i <= 1'b0;
        t0 = cyc;
        res(5 * P, t, q);
        chkr(t - t0, 4 * P - P / 4, 4 * P + P / 4, "channel settle");
        t0 = t;
        res(2 * P, t, q);
        chkr(t - t0, P - 8, P + 8, "channel stream");
        $display("test channel change done");
        dens <= 2'd1;
        run(32'h0000_0401, 32'h0000_0000, 4 * P, P, 2, q);
        dens <= 2'd2;
        run(32'h0000_0801, 32'h0000_0000, 4 * P, 4 * P, 2, q);
        bus(0, 4'h8, 32'h0000_0000, q);
        chk(q & 32'h0000_0008, 32'h0000_0008, "zero latency on");
        run(32'h0000_0001, 32'h0000_0001, 4 * P, 4 * P, 2, q);
        bus(0, 4'h8, 32'h0000_0000, q);
        chk(q & 32'h0000_0008, 32'h0000_0008, "forced zero latency");
        run(32'h0000_8001, 32'h0000_0000, 3 * P, P, 2, q);
        complete_run();
    end
endmodule : sdf_top_tb_top
